// file: hw/acw_sync.sv
// Two-stage synchroniser for asynchronous inputs
`timescale 1ns/1ns
module acw_sync
  import acw_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } acw_sync_state_t;

  acw_sync_state_t st_reg;
  acw_sync_state_t st_next;

  if (WIDTH < 1) begin : g_bad_width
    $error("acw_sync: WIDTH must be at least 1");
  end

  always_comb begin
    st_next = st_reg;
    st_next.meta = i_async;
    st_next.sync = st_reg.meta;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_sync = st_reg.sync;

endmodule : acw_sync

// file: hw/acw_wrapper.sv
// Digital control wrapper around the on-chip voltage comparator
//
// Behaviour
// - Result pin drives only with debug pin disabled
// - Capture route feeds comparator into channel zero
// - Capture route removes channel zero pin externally
// - Interrupt on rising, falling or either edge
// - Enabled comparator keeps running in wait
// - Enabled compare event in wait raises wake
// - Comparator disabled in every stop mode
// - No wake-up from any stop mode
// - Deep stops power down, wake at reset
// - Light stop halts clocks, holds registers, low-power
// - No compare or flag during light stop
// - Reset out of light stop restores reset
// - Interrupt exit of light stop resumes state
// - Edge field: 00/10 fall, 01 rise, 11 any
// - Flag set by event, cleared by writing one
// - Status shows output, zero when module disabled
// - Interrupt asserted while flag and enable set in run mode; held low in light stop
`timescale 1ns/1ns
module acw_wrapper
  import acw_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_cmp_raw,
  input wire logic i_timer_channel_zero_pin,
  input wire logic i_comparator_module_enable,
  input wire logic i_bandgap_select,
  input wire logic i_bandgap_buffer_enable,
  input wire logic i_compare_irq_enable,
  input wire logic [1:0] i_event_edge_select,
  input wire logic i_flag_clear,
  input wire logic i_output_pin_enable,
  input wire logic i_debug_pin_enable,
  input wire logic i_compare_to_capture_route,
  input wire logic i_timer_ch0_out,
  input wire logic i_timer_ch0_oe,
  input wire logic i_wait_mode,
  input wire acw_power_t i_power_mode,
  output logic o_compare_event_flag,
  output logic o_compare_output_status,
  output logic o_compare_irq,
  output logic o_wake_request,
  output logic o_compare_result_pin,
  output logic o_compare_result_pin_oe,
  output logic o_capture_ch0_in,
  output logic o_timer_channel_zero_pin,
  output logic o_timer_channel_zero_pin_oe,
  output logic o_analog_enable,
  output logic o_analog_low_power,
  output logic o_bandgap_ref_select
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset value and state

  localparam acw_state_t ACW_RESET_STATE = '{
    cmp_prev: 1'b0,
    en_prev: 1'b0,
    flag: ACW_RST_FLAG,
    status: ACW_RST_STATUS,
    irq: 1'b0,
    wake: 1'b0,
    res_pin: ACW_RST_PIN,
    res_oe: 1'b0,
    cap_in: 1'b0,
    ch0_out: 1'b0,
    ch0_oe: 1'b0,
    ana_en: 1'b0,
    ana_lp: 1'b0,
    ref_bg: 1'b0
  };

  acw_state_t st_reg;
  acw_state_t st_next;
  logic [1:0] sync_q;
  logic cmp_s;
  logic pin_s;
  logic run;
  logic en;
  logic rise;
  logic fall;
  logic hit;
  logic cmp_en;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  acw_sync #(
    .WIDTH(ACW_SYNC_STAGES)
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_async({i_timer_channel_zero_pin, i_cmp_raw}),
    .o_sync(sync_q)
  );

  assign cmp_s = sync_q[0];
  assign pin_s = sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection

  assign run = (i_power_mode == ACW_RUN);
  assign en = i_comparator_module_enable && run;
  assign cmp_en = cmp_s && en;
  assign rise = cmp_s && !st_reg.cmp_prev;
  assign fall = !cmp_s && st_reg.cmp_prev;

  always_comb begin
    hit = 1'b0;
    unique case (i_event_edge_select)
      ACW_EDGE_FALL_A: hit = fall;
      ACW_EDGE_RISE: hit = rise;
      ACW_EDGE_FALL_B: hit = fall;
      ACW_EDGE_ANY: hit = rise || fall;
    endcase
    hit = hit && en && st_reg.en_prev;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_next = st_reg;
    unique case (i_power_mode)
      ACW_DEEP_STOP, ACW_DEEPEST_STOP: begin
        st_next = ACW_RESET_STATE;
      end
      ACW_LIGHT_STOP: begin
        st_next.ana_en = 1'b0;
        st_next.ana_lp = 1'b1;
        st_next.irq = 1'b0;
        st_next.wake = 1'b0;
        st_next.en_prev = 1'b0;
        st_next.res_oe = st_reg.res_oe && !i_debug_pin_enable;
      end
      ACW_RUN: begin
        st_next.cmp_prev = cmp_s;
        st_next.en_prev = en;
        if (hit) begin
          st_next.flag = 1'b1;
        end else if (i_flag_clear) begin
          st_next.flag = 1'b0;
        end
        st_next.status = cmp_en;
        st_next.irq = i_compare_irq_enable && st_next.flag;
        st_next.wake = st_next.irq && i_wait_mode;
        st_next.res_pin = cmp_en;
        st_next.res_oe = en && i_output_pin_enable && !i_debug_pin_enable;
        st_next.cap_in = i_compare_to_capture_route ? cmp_en : pin_s;
        st_next.ch0_out = i_timer_ch0_out;
        st_next.ch0_oe = i_timer_ch0_oe && !i_compare_to_capture_route;
        st_next.ana_en = i_comparator_module_enable;
        st_next.ana_lp = 1'b0;
        st_next.ref_bg = i_bandgap_select && i_bandgap_buffer_enable;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st_reg <= ACW_RESET_STATE;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_compare_event_flag = st_reg.flag;
  assign o_compare_output_status = st_reg.status;
  assign o_compare_irq = st_reg.irq;
  assign o_wake_request = st_reg.wake;
  assign o_compare_result_pin = st_reg.res_pin;
  assign o_compare_result_pin_oe = st_reg.res_oe;
  assign o_capture_ch0_in = st_reg.cap_in;
  assign o_timer_channel_zero_pin = st_reg.ch0_out;
  assign o_timer_channel_zero_pin_oe = st_reg.ch0_oe;
  assign o_analog_enable = st_reg.ana_en;
  assign o_analog_low_power = st_reg.ana_lp;
  assign o_bandgap_ref_select = st_reg.ref_bg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb_sys @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  property p_flag_on_rise;
    en && st_reg.en_prev && i_event_edge_select == ACW_EDGE_RISE && cmp_s && !st_reg.cmp_prev
      |=> o_compare_event_flag && (o_compare_irq == $past(i_compare_irq_enable));
  endproperty
  a_flag_on_rise: assert property (p_flag_on_rise)
    else $error("flag not set on rising edge");

  property p_flag_clear;
    run && i_flag_clear && !hit |=> !o_compare_event_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag not cleared by write one");

  property p_status_off;
    run && !i_comparator_module_enable |=> !o_compare_output_status && !o_compare_result_pin;
  endproperty
  a_status_off: assert property (p_status_off)
    else $error("status not zero while disabled");

  property p_irq_follows;
    o_compare_irq |-> o_compare_event_flag && $past(i_compare_irq_enable);
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("interrupt without flag and enable");

  property p_no_stop_wake;
    !run |=> !o_wake_request && !o_compare_irq && !o_analog_enable;
  endproperty
  a_no_stop_wake: assert property (p_no_stop_wake)
    else $error("wake or analog enable during stop");

  property p_deep_reset;
    (i_power_mode == ACW_DEEP_STOP || i_power_mode == ACW_DEEPEST_STOP)
      |=> !o_compare_event_flag && !o_compare_output_status && !o_compare_result_pin_oe;
  endproperty
  a_deep_reset: assert property (p_deep_reset)
    else $error("state not reset in deep stop");

  property p_light_hold;
    i_power_mode == ACW_LIGHT_STOP
      |=> $stable(o_compare_event_flag) && $stable(o_compare_output_status) && o_analog_low_power;
  endproperty
  a_light_hold: assert property (p_light_hold)
    else $error("state changed in light stop");

  property p_route_pin;
    run && i_compare_to_capture_route |=> !o_timer_channel_zero_pin_oe && o_capture_ch0_in == $past(cmp_en);
  endproperty
  a_route_pin: assert property (p_route_pin)
    else $error("capture route not applied");

  property p_debug_pin;
    i_debug_pin_enable |=> !o_compare_result_pin_oe;
  endproperty
  a_debug_pin: assert property (p_debug_pin)
    else $error("result pin driven with debug pin enabled");

  property p_fall_event;
    en && st_reg.en_prev && (i_event_edge_select == ACW_EDGE_FALL_A || i_event_edge_select == ACW_EDGE_FALL_B)
      && !cmp_s && st_reg.cmp_prev |=> o_compare_event_flag;
  endproperty
  a_fall_event: assert property (p_fall_event)
    else $error("flag not set on falling edge");

  property p_any_event;
    en && st_reg.en_prev && i_event_edge_select == ACW_EDGE_ANY && (cmp_s != st_reg.cmp_prev) |=> o_compare_event_flag;
  endproperty
  a_any_event: assert property (p_any_event)
    else $error("flag not set on toggle");

  property p_rise_only;
    run && i_event_edge_select == ACW_EDGE_RISE && !(cmp_s && !st_reg.cmp_prev) && !o_compare_event_flag
      |=> !o_compare_event_flag;
  endproperty
  a_rise_only: assert property (p_rise_only)
    else $error("flag set without rising edge");

  property p_ch0_pass;
    run && !i_compare_to_capture_route |=> o_timer_channel_zero_pin_oe == $past(i_timer_ch0_oe);
  endproperty
  a_ch0_pass: assert property (p_ch0_pass)
    else $error("channel zero pin enable not passed through");

  property p_wait_wake;
    run && i_wait_mode && i_compare_irq_enable && hit |=> o_wake_request;
  endproperty
  a_wait_wake: assert property (p_wait_wake)
    else $error("no wake on event in wait");

  property p_wait_runs;
    run && i_wait_mode && i_comparator_module_enable |=> o_analog_enable;
  endproperty
  a_wait_runs: assert property (p_wait_runs)
    else $error("comparator stopped in wait");

  property p_no_stale_edge;
    $past(i_power_mode) == ACW_LIGHT_STOP && run |-> !hit;
  endproperty
  a_no_stale_edge: assert property (p_no_stale_edge)
    else $error("event taken from light stop");

  property p_resume;
    $past(i_power_mode) == ACW_LIGHT_STOP && run |-> $stable(o_compare_event_flag) && $stable(o_compare_output_status);
  endproperty
  a_resume: assert property (p_resume)
    else $error("state lost over light stop");

  property p_reset_quiet;
    $past(!i_rst_n) |-> !o_compare_event_flag && !o_compare_irq && !o_compare_result_pin_oe;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("state not reset after reset");

endmodule : acw_wrapper

// file: include/acw_pkg.sv
// Shared constants and types for the analog comparator wrapper
package acw_pkg;

  localparam int ACW_SYNC_STAGES = 2;

  localparam logic [1:0] ACW_EDGE_FALL_A = 2'h0;
  localparam logic [1:0] ACW_EDGE_RISE = 2'h1;
  localparam logic [1:0] ACW_EDGE_FALL_B = 2'h2;
  localparam logic [1:0] ACW_EDGE_ANY = 2'h3;

  localparam logic ACW_RST_FLAG = 1'b0;
  localparam logic ACW_RST_STATUS = 1'b0;
  localparam logic ACW_RST_PIN = 1'b0;

  typedef enum logic [1:0] {
    ACW_RUN,
    ACW_LIGHT_STOP,
    ACW_DEEP_STOP,
    ACW_DEEPEST_STOP
  } acw_power_t;

  typedef struct packed {
    logic cmp_prev;
    logic en_prev;
    logic flag;
    logic status;
    logic irq;
    logic wake;
    logic res_pin;
    logic res_oe;
    logic cap_in;
    logic ch0_out;
    logic ch0_oe;
    logic ana_en;
    logic ana_lp;
    logic ref_bg;
  } acw_state_t;

endpackage : acw_pkg

// file: tb/acw_analog_model.sv
// Behavioural comparator standing outside the wrapper
`timescale 1ns/1ns
module acw_analog_model (
  input wire logic i_pos_above,
  input wire logic i_bg_above,
  input wire logic i_bandgap_ref_select,
  output logic o_cmp_raw
);
  // Bandgap reference only reaches the input with its buffer on
  assign o_cmp_raw = i_bandgap_ref_select ? i_bg_above : i_pos_above;
endmodule : acw_analog_model

// file: tb/test_acw_wrapper.sv
// Self-checking bench for the comparator wrapper
`timescale 1ns/1ns
module test_acw_wrapper;
  import acw_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, pos = 1'b0, bg = 1'b0, en = 1'b0, bgs = 1'b0, bandgap_buffer_enable = 1'b0;
  logic ie = 1'b0, clr = 1'b0, ope = 1'b0, dbg = 1'b1, route = 1'b0, t_out = 1'b1, t_oe = 1'b1;
  logic wt = 1'b0, pad = 1'b0;
  logic [1:0] esel = 2'h0;
  acw_power_t pm = ACW_RUN;
  logic raw, flag, stat, irq, wake, rpin, rpin_oe, cap, ch0, ch0_oe, a_en, a_lp, bgr;
  int n_mismatch = 0, compares = 0;

  always #5 clk = ~clk;

  acw_wrapper DUT (.i_clk_sys(clk), .i_rst_n(rst_n), .i_cmp_raw(raw), .i_timer_channel_zero_pin(pad),
    .i_comparator_module_enable(en), .i_bandgap_select(bgs), .i_bandgap_buffer_enable(bandgap_buffer_enable),
    .i_compare_irq_enable(ie), .i_event_edge_select(esel), .i_flag_clear(clr), .i_output_pin_enable(ope),
    .i_debug_pin_enable(dbg), .i_compare_to_capture_route(route), .i_timer_ch0_out(t_out),
    .i_timer_ch0_oe(t_oe), .i_wait_mode(wt), .i_power_mode(pm), .o_compare_event_flag(flag),
    .o_compare_output_status(stat), .o_compare_irq(irq), .o_wake_request(wake), .o_compare_result_pin(rpin),
    .o_compare_result_pin_oe(rpin_oe), .o_capture_ch0_in(cap), .o_timer_channel_zero_pin(ch0),
    .o_timer_channel_zero_pin_oe(ch0_oe), .o_analog_enable(a_en), .o_analog_low_power(a_lp),
    .o_bandgap_ref_select(bgr));

  acw_analog_model MODEL (.i_pos_above(pos), .i_bg_above(bg), .i_bandgap_ref_select(bgr), .o_cmp_raw(raw));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic chk(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  task automatic pulse_clear;
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(1);
  endtask : pulse_clear

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    cyc(8);
    rst_n = 1'b1;
    cyc(2);
    chk(flag, ACW_RST_FLAG, "flag at reset");
    chk(stat, ACW_RST_STATUS, "status at reset");
    en = 1'b1;
    ie = 1'b1;
    cyc(4);
    for (int m = 0; m < 4; m++) begin
      esel = 2'(m);
      pos = 1'b1;
      cyc(6);
      chk(stat, 1'b1, "status");
      chk(flag, m[0], "rise flag");
      chk(irq, m[0], "irq");
      pulse_clear();
      chk(flag, 1'b0, "clear");
      pos = 1'b0;
      cyc(6);
      chk(flag, m != 1, "fall flag");
      pulse_clear();
    end
    en = 1'b0;
    pos = 1'b1;
    cyc(6);
    chk(stat, 1'b0, "status off");
    chk(flag, 1'b0, "event off");
    en = 1'b1;
    cyc(6);
    route = 1'b1;
    cyc(2);
    chk(ch0_oe, 1'b0, "ch0 hidden");
    chk(cap, 1'b1, "capture routed");
    route = 1'b0;
    cyc(4);
    chk(ch0_oe, 1'b1, "ch0 back");
    chk(ch0, 1'b1, "ch0 data");
    chk(cap, 1'b0, "capture pad");
    ope = 1'b1;
    cyc(2);
    chk(rpin_oe, 1'b0, "pin with debug");
    dbg = 1'b0;
    cyc(2);
    chk(rpin_oe, 1'b1, "pin oe");
    chk(rpin, 1'b1, "pin data");
    esel = ACW_EDGE_ANY;
    bandgap_buffer_enable = 1'b1;
    bgs = 1'b1;
    cyc(6);
    chk(bgr, 1'b1, "bandgap ref");
    chk(stat, 1'b0, "bandgap compare");
    pulse_clear();
    wt = 1'b1;
    bg = 1'b1;
    cyc(6);
    chk(flag, 1'b1, "runs in wait");
    chk(wake, 1'b1, "wake");
    wt = 1'b0;
    bg = 1'b0;
    cyc(6);
    pulse_clear();
    pm = ACW_LIGHT_STOP;
    cyc(2);
    chk(a_lp, 1'b1, "low power");
    chk(a_en, 1'b0, "analog off");
    bg = 1'b1;
    cyc(6);
    chk(flag, 1'b0, "no event in stop");
    bg = 1'b0;
    cyc(4);
    pm = ACW_RUN;
    cyc(6);
    chk(flag, 1'b0, "resume quiet");
    bg = 1'b1;
    cyc(6);
    pm = ACW_LIGHT_STOP;
    wt = 1'b1;
    cyc(2);
    chk(irq, 1'b0, "no stop wake");
    chk(wake, 1'b0, "no wake in stop");
    chk(flag, 1'b1, "flag held");
    pm = ACW_RUN;
    wt = 1'b0;
    cyc(2);
    chk(irq, 1'b1, "irq resumed");
    pm = ACW_LIGHT_STOP;
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    pm = ACW_RUN;
    cyc(2);
    chk(flag, 1'b0, "reset from stop");
    cyc(4);
    for (int p = 2; p < 4; p++) begin
      bg = ~bg;
      cyc(6);
      chk(flag, 1'b1, "flag before stop");
      pm = acw_power_t'(p);
      cyc(2);
      chk(flag, 1'b0, "deep stop reset");
      chk(a_en, 1'b0, "deep analog off");
      pm = ACW_RUN;
      cyc(4);
    end
    pm = ACW_LIGHT_STOP;
    bg = 1'b0;
    cyc(6);
    pm = ACW_RUN;
    cyc(6);
    chk(flag, 1'b0, "no stale edge after stop");
    ie = 1'b0;
    en = 1'b0;
    wt = 1'b1;
    cyc(2);
    chk(a_en, 1'b0, "idle comparator off in wait");
    chk(wake, 1'b0, "no wake when unused");
    tally_and_finish();
  end
endmodule : test_acw_wrapper
